/* include/autoneg_pkg.sv */
package autoneg_pkg;

  // Bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [4:0] ADV_OFF  = 5'h04;
  localparam logic [4:0] LPA_OFF  = 5'h05;
  localparam logic [4:0] EXP_OFF  = 5'h06;
  localparam logic [4:0] NPT_OFF  = 5'h07;
  localparam logic [4:0] LPN_OFF  = 5'h08;
  localparam logic [4:0] GBC_OFF  = 5'h09;
  localparam logic [4:0] IST_OFF  = 5'h1E;
  localparam logic [4:0] IMSK_OFF = 5'h1F;

  // Reset values
  localparam logic [15:0] ADV_RST  = 16'h01E1;
  localparam logic [15:0] NPT_RST  = 16'h2001;
  localparam logic [15:0] GBC_RST  = 16'h0700;
  localparam logic [15:0] ZERO_RST = 16'h0000;

  // Software writable bits
  localparam logic [15:0] ADV_WMASK = 16'hAFFF;
  localparam logic [15:0] NPT_WMASK = 16'hB7FF;
  localparam logic [15:0] GBC_WMASK = 16'hFF00;
  // Bits kept from a received base page
  localparam logic [15:0] LPA_MASK  = 16'hEFFF;

  // Expansion field positions
  localparam int EXP_PDF   = 4;
  localparam int EXP_LPNP  = 3;
  localparam int EXP_LOCNP = 2;
  localparam int EXP_PGRX  = 1;
  localparam int EXP_LPAN  = 0;

  // Next page transmit toggle position
  localparam int NPT_TOGGLE = 11;

  // Gigabit control field positions
  localparam int GBC_TEST_HI = 15;
  localparam int GBC_TEST_LO = 13;
  localparam int GBC_MANUAL  = 12;
  localparam int GBC_MSVAL   = 11;
  localparam int GBC_PORT    = 10;
  localparam int GBC_FD      = 9;
  localparam int GBC_HD      = 8;

  // Test mode codes
  localparam int          TEST_MODES  = 4;
  localparam logic [2:0]  TEST_NORMAL = 3'h0;

  // Interrupt status bits
  localparam int IRQ_W      = 3;
  localparam int IRQ_PGRX   = 0;
  localparam int IRQ_PDF    = 1;
  localparam int IRQ_NPSENT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

endpackage

/* core/autoneg_page_register_set.sv */
// How it works
// - Pause advertise bits 11,10 writable, reset zero
// - Speed bits 8:5 reset one, bit9 zero
// - Selector field writable, resets to 00001
// - Next page 15, fault 13 writable; 14 zero
// - Partner base page read-only, reset zero
// - Parallel fault latches high until read
// - Page received latches until read
// - Expansion bit2 one; bits 3,0 partner
// - Next page bits 15,13, code writable
// - Bit 12 comply flag writable, resets zero
// - Toggle reads inverse of last sent
// - Partner next page read-only, reset zero
// - Test field selects modes one to four
// - Master value applies only when manual
// - Port type and gigabit abilities reset one
`timescale 1ns/1ps
module autoneg_page_register_set
  import autoneg_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic [DATA_W-1:0] i_lp_base_page,
  input  wire logic              i_lp_base_valid,
  input  wire logic [DATA_W-1:0] i_lp_next_page,
  input  wire logic              i_lp_np_valid,
  input  wire logic              i_par_det_fault,
  input  wire logic              i_lp_np_able,
  input  wire logic              i_lp_an_able,
  input  wire logic              i_np_sent,
  input  wire logic              i_sent_toggle,
  output logic      [DATA_W-1:0] o_adv_word,
  output logic      [DATA_W-1:0] o_np_word,
  output logic      [3:0]        o_test_sel,
  output logic                   o_force_master,
  output logic                   o_force_slave,
  output logic                   o_port_multi,
  output logic                   o_adv_1000_fd,
  output logic                   o_adv_1000_hd,
  output logic                   o_irq
);

  // Register state
  logic [DATA_W-1:0] adv_ff;    // Local advertisement
  logic [DATA_W-1:0] lpa_ff;    // Partner base page
  logic [DATA_W-1:0] npt_ff;    // Next page transmit
  logic [DATA_W-1:0] lpn_ff;    // Partner next page
  logic [DATA_W-1:0] gbc_ff;    // Gigabit control
  logic              pdf_ff;    // Parallel fault latch
  logic              pgrx_ff;   // Page received latch
  logic              tog_ff;    // Toggle readback
  logic [IRQ_W-1:0]  ist_ff;    // Interrupt status
  logic [IRQ_W-1:0]  imsk_ff;   // Interrupt mask

  // Next values
  logic              nxt_pdf;
  logic              nxt_pgrx;
  logic [IRQ_W-1:0]  nxt_ist;

  // Address decode
  wire hit_adv  = (i_addr == ADV_OFF);
  wire hit_lpa  = (i_addr == LPA_OFF);
  wire hit_exp  = (i_addr == EXP_OFF);
  wire hit_npt  = (i_addr == NPT_OFF);
  wire hit_lpn  = (i_addr == LPN_OFF);
  wire hit_gbc  = (i_addr == GBC_OFF);
  wire hit_ist  = (i_addr == IST_OFF);
  wire hit_imsk = (i_addr == IMSK_OFF);

  // Write strobes per register
  wire wr_adv  = i_wr && hit_adv;
  wire wr_npt  = i_wr && hit_npt;
  wire wr_gbc  = i_wr && hit_gbc;
  wire wr_ist  = i_wr && hit_ist;
  wire wr_imsk = i_wr && hit_imsk;
  // Read of expansion clears its latches
  wire rd_exp  = i_rd && hit_exp;

  // Masked write images; reserved bits forced to reset
  // reserved bits fixed
  wire [DATA_W-1:0] adv_wval = (i_wdata & ADV_WMASK)
                             | (ADV_RST & ~ADV_WMASK);
  wire [DATA_W-1:0] npt_wval = (i_wdata & NPT_WMASK)
                             | (NPT_RST & ~NPT_WMASK);
  wire [DATA_W-1:0] gbc_wval = (i_wdata & GBC_WMASK)
                             | (GBC_RST & ~GBC_WMASK);

  // Any new page from the partner
  wire page_in = i_lp_base_valid || i_lp_np_valid;

  // Expansion word view
  // fixed local next page ability
  wire [DATA_W-1:0] exp_view = {11'h000,
                                pdf_ff,
                                i_lp_np_able,
                                1'b1,
                                pgrx_ff,
                                i_lp_an_able};

  // Next page word with live toggle
  // toggle inserted on read
  wire [DATA_W-1:0] npt_view = {npt_ff[15:12],
                                tog_ff,
                                npt_ff[10:0]};

  // Read selection; unmapped reads zero
  wire [DATA_W-1:0] rd_mux =
      hit_adv  ? adv_ff   :
      hit_lpa  ? lpa_ff   :
      hit_exp  ? exp_view :
      hit_npt  ? npt_view :
      hit_lpn  ? lpn_ff   :
      hit_gbc  ? gbc_ff   :
      hit_ist  ? {13'h0000, ist_ff}  :
      hit_imsk ? {13'h0000, imsk_ff} :
      ZERO_RST;

  // Latch update terms; set wins over read clear
  // parallel fault latch
  assign nxt_pdf  = i_par_det_fault || (pdf_ff && !rd_exp);
  assign nxt_pgrx = page_in || (pgrx_ff && !rd_exp);

  // Event vector for interrupt status
  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_PGRX]   = page_in;
  assign irq_ev[IRQ_PDF]    = i_par_det_fault;
  assign irq_ev[IRQ_NPSENT] = i_np_sent;

  // Write one to clear, events win
  wire [IRQ_W-1:0] ist_clr = wr_ist ? i_wdata[IRQ_W-1:0] : IRQ_RST;
  assign nxt_ist = irq_ev | (ist_ff & ~ist_clr);

  // Test field decode, one line per mode
  wire [2:0] test_code = gbc_ff[GBC_TEST_HI:GBC_TEST_LO];
  wire [3:0] test_dec;
  genvar m;
  generate
    for (m = 0; m < TEST_MODES; m = m + 1) begin : g_test
      assign test_dec[m] = (test_code == 3'(m + 1));
    end
  endgenerate

  // Master/slave forcing
  // gated by manual bit
  wire ms_manual = gbc_ff[GBC_MANUAL];
  wire force_m   = ms_manual && gbc_ff[GBC_MSVAL];
  wire force_s   = ms_manual && !gbc_ff[GBC_MSVAL];

  // Local advertisement register
  // pause bits writable
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      adv_ff <= ADV_RST;
    end else if (wr_adv) begin
      adv_ff <= adv_wval;
    end
  end

  // Partner base page capture
  // read-only partner page
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lpa_ff <= ZERO_RST;
    end else if (i_lp_base_valid) begin
      lpa_ff <= i_lp_base_page & LPA_MASK;
    end
  end

  // Next page transmit register
  // more pages, message, code
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      npt_ff <= NPT_RST;
    end else if (wr_npt) begin
      npt_ff <= npt_wval;
    end
  end

  // Toggle follows the last sent codeword
  // inverse of sent toggle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tog_ff <= 1'b0;
    end else if (i_np_sent) begin
      tog_ff <= !i_sent_toggle;
    end
  end

  // Partner next page capture
  // read-only partner next page
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lpn_ff <= ZERO_RST;
    end else if (i_lp_np_valid) begin
      lpn_ff <= i_lp_next_page;
    end
  end

  // Gigabit control register
  // port type and ability reset
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gbc_ff <= GBC_RST;
    end else if (wr_gbc) begin
      gbc_ff <= gbc_wval;
    end
  end

  // Expansion latches
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pdf_ff  <= 1'b0;
      pgrx_ff <= 1'b0;
    end else begin
      pdf_ff  <= nxt_pdf;
      pgrx_ff <= nxt_pgrx;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ist_ff  <= IRQ_RST;
      imsk_ff <= IRQ_RST;
    end else begin
      ist_ff <= nxt_ist;
      if (wr_imsk) begin
        imsk_ff <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // Read data, valid only the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= ZERO_RST;
    end else begin
      o_rdata <= i_rd ? rd_mux : ZERO_RST;
    end
  end

  // Registered control outputs to the negotiation engine
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_adv_word     <= ADV_RST;
      o_np_word      <= NPT_RST;
      o_test_sel     <= 4'h0;
      o_force_master <= 1'b0;
      o_force_slave  <= 1'b0;
      o_port_multi   <= GBC_RST[GBC_PORT];
      o_adv_1000_fd  <= GBC_RST[GBC_FD];
      o_adv_1000_hd  <= GBC_RST[GBC_HD];
    end else begin
      o_adv_word     <= adv_ff;
      o_np_word      <= npt_view;
      o_test_sel     <= test_dec;
      o_force_master <= force_m;
      o_force_slave  <= force_s;
      o_port_multi   <= gbc_ff[GBC_PORT];
      o_adv_1000_fd  <= gbc_ff[GBC_FD];
      o_adv_1000_hd  <= gbc_ff[GBC_HD];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ist_ff & imsk_ff);
    end
  end

endmodule

/* tb/autoneg_asserts.sv */
`timescale 1ns/1ps
module autoneg_asserts
  import autoneg_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_reset,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [DATA_W-1:0] i_lp_base_page,
  input wire logic              i_lp_base_valid,
  input wire logic              i_par_det_fault,
  input wire logic              i_lp_np_able,
  input wire logic              i_lp_an_able,
  input wire logic              i_np_sent,
  input wire logic              i_sent_toggle,
  input wire logic [DATA_W-1:0] o_adv_word,
  input wire logic [DATA_W-1:0] o_np_word,
  input wire logic [3:0]        o_test_sel,
  input wire logic              o_force_master,
  input wire logic              o_force_slave,
  input wire logic              o_port_multi,
  input wire logic              o_adv_1000_fd,
  input wire logic              o_adv_1000_hd
);
  // Address decodes of interest
  wire wr_adv = i_wr && i_addr == ADV_OFF;
  wire wr_gbc = i_wr && i_addr == GBC_OFF;
  wire rd_exp = i_rd && i_addr == EXP_OFF;
  wire rd_lpa = i_rd && i_addr == LPA_OFF;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // One-hot test select from the written code
  function automatic logic [3:0] sel(input logic [2:0] c);
    sel = (c == 3'h0 || c > 3'h4) ? 4'h0 : 4'h1 << (c - 3'h1);
  endfunction
  // A single write followed by a quiet cycle
  sequence adv_s; wr_adv ##1 !wr_adv; endsequence
  sequence gbc_s; wr_gbc ##1 !wr_gbc; endsequence
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data outside its slot");
  adv_copy_a: assert property (adv_s |=>
    o_adv_word == ($past(i_wdata, 2) & ADV_WMASK)) else $error("adv copy");
  test_sel_a: assert property (gbc_s |=>
    o_test_sel == sel($past(i_wdata[15:13], 2))) else $error("test sel");
  force_role_a: assert property (gbc_s |=>
    {o_force_master, o_force_slave} == {$past(i_wdata[12] & i_wdata[11], 2),
    $past(i_wdata[12] & !i_wdata[11], 2)}) else $error("role force");
  gig_adv_a: assert property (gbc_s |=>
    {o_port_multi, o_adv_1000_fd, o_adv_1000_hd} == $past(i_wdata[10:8], 2))
    else $error("gigabit advertise");
  base_cap_a: assert property (
    i_lp_base_valid ##1 (rd_lpa && !i_lp_base_valid)
    |=> o_rdata == ($past(i_lp_base_page, 2) & LPA_MASK))
    else $error("base page capture");
  exp_live_a: assert property (rd_exp |=> o_rdata[2] &&
    o_rdata[3] == $past(i_lp_np_able) && o_rdata[0] == $past(i_lp_an_able))
    else $error("expansion live bits");
  fault_hold_a: assert property (
    i_par_det_fault ##1 rd_exp |=> o_rdata[4])
    else $error("fault not latched");
  fault_clr_a: assert property ((rd_exp && !i_par_det_fault) ##1
    (rd_exp && !i_par_det_fault) |=> !o_rdata[4]) else $error("fault kept");
  toggle_inv_a: assert property (i_np_sent ##1 !i_np_sent |=>
    o_np_word[NPT_TOGGLE] == !$past(i_sent_toggle, 2)) else $error("toggle");
endmodule
bind autoneg_page_register_set autoneg_asserts u_autoneg_asserts (.*);

/* tb/lp_model.sv */
`timescale 1ns/1ps
module lp_model
  import autoneg_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic              i_send_base,
  input  wire logic              i_send_np,
  input  wire logic [DATA_W-1:0] i_page,
  output logic      [DATA_W-1:0] o_page       = 16'hA5A5,
  output logic                   o_base_valid = 1'b0,
  output logic                   o_np_valid   = 1'b0,
  output logic                   o_np_able    = 1'b0,
  output logic                   o_an_able    = 1'b0
);
  // One-cycle page strobes; idle page lines show the inverse pattern
  always @(posedge i_mclk) begin
    o_base_valid <= i_send_base && !i_reset;
    o_np_valid <= i_send_np && !i_reset;
    o_page <= (i_send_base || i_send_np) ? i_page : ~o_page;
    // Abilities known once a base page went out
    if (i_reset) begin
      o_an_able <= 1'b0;
      o_np_able <= 1'b0;
    end else if (i_send_base) begin
      o_an_able <= 1'b1;
      o_np_able <= i_page[15];
    end
  end
endmodule

/* tb/autoneg_page_register_set_tb_top.sv */
`timescale 1ns/1ps
module autoneg_page_register_set_tb_top;
  import autoneg_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_reset = 1'b1;
  logic [4:0]  i_addr = 5'h0;
  logic [15:0] i_wdata = 16'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        rd_ff = 1'b0;
  wire  [15:0] o_rdata, lp_page;
  wire         o_irq, lp_bv, lp_nv, lp_np, lp_an;
  logic [15:0] exp_q [$];
  logic [31:0] r = 32'h8D77;
  logic [15:0] npt;
  int          fail_count = 0, total_checks = 0, cyc_n = 0, k;
  logic [4:0]  offs [9] = '{ADV_OFF, LPA_OFF, EXP_OFF, NPT_OFF, LPN_OFF,
                            GBC_OFF, IST_OFF, IMSK_OFF, 5'h0A};
  logic [15:0] rstv [9] = '{ADV_RST, ZERO_RST, 16'h0004, NPT_RST, ZERO_RST,
                            GBC_RST, ZERO_RST, ZERO_RST, ZERO_RST};
  autoneg_page_register_set u_autoneg_page_register_set (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_lp_base_page(lp_page),
    .i_lp_base_valid(lp_bv), .i_lp_next_page(lp_page), .i_lp_np_valid(lp_nv),
    .i_par_det_fault(ev[1]), .i_lp_np_able(lp_np), .i_lp_an_able(lp_an),
    .i_np_sent(ev[0]), .i_sent_toggle(i_wdata[0]), .o_adv_word(),
    .o_np_word(), .o_test_sel(), .o_force_master(), .o_force_slave(),
    .o_port_multi(), .o_adv_1000_fd(), .o_adv_1000_hd(), .o_irq(o_irq));
  lp_model u_lp_model (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_send_base(ev[3]),
    .i_send_np(ev[2]), .i_page(i_wdata), .o_page(lp_page),
    .o_base_valid(lp_bv), .o_np_valid(lp_nv), .o_np_able(lp_np),
    .o_an_able(lp_an));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // One bus cycle with its engine events
  task cyc(input logic w, rd, input logic [4:0] a, input logic [15:0] d,
           input logic [3:0] e);
    i_wr <= w;
    i_rd <= rd;
    i_addr <= a;
    i_wdata <= d;
    ev <= e;
    @(posedge i_mclk);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d, 4'h0);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 16'h0, 4'h0);
  endtask
  // Idle a cycle, then look at the interrupt line once settled
  task irq_is(input logic e);
    cyc(1'b0, 1'b0, 5'h0, 16'h0, 4'h0);
    #1;
    chk({15'h0, o_irq}, {15'h0, e});
    @(posedge i_mclk);
  endtask
  task end_sim();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read data checked against the oldest note
  always @(posedge i_mclk) begin
    if (rd_ff) chk(o_rdata, exp_q.pop_front());
    rd_ff <= i_rd;
  end
  // Hang guard
  always @(posedge i_mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (k = 0; k < 9; k++) rd(offs[k], rstv[k]);
    for (k = 0; k < 8; k++) begin
      r = lfsr(r);
      npt = r[31:16] & NPT_WMASK;
      wr(ADV_OFF, r[15:0]);
      wr(NPT_OFF, r[31:16]);
      wr(GBC_OFF, {k[2:0], r[12:0]});
      wr(LPA_OFF, r[15:0]);
      wr(EXP_OFF, r[15:0]);
      wr(LPN_OFF, r[15:0]);
      wr(5'h0A, r[15:0]);
      rd(ADV_OFF, r[15:0] & ADV_WMASK);
      rd(NPT_OFF, npt);
      rd(GBC_OFF, {k[2:0], r[12:8], 8'h00});
      rd(LPA_OFF, ZERO_RST);
      rd(EXP_OFF, 16'h0004);
      rd(LPN_OFF, ZERO_RST);
      rd(5'h0A, ZERO_RST);
    end
    cyc(1'b0, 1'b0, 5'h0, r[15:0] | 16'h8000, 4'h8);
    cyc(1'b0, 1'b0, 5'h0, 16'h0, 4'h0);
    rd(LPA_OFF, (r[15:0] | 16'h8000) & LPA_MASK);
    rd(EXP_OFF, 16'h000F);
    rd(EXP_OFF, 16'h000D);
    rd(IST_OFF, 16'h0001);
    irq_is(1'b0);
    wr(IMSK_OFF, 16'h0007);
    irq_is(1'b1);
    wr(IST_OFF, 16'h0001);
    irq_is(1'b0);
    cyc(1'b0, 1'b0, 5'h0, ~r[15:0], 4'h4);
    cyc(1'b0, 1'b0, 5'h0, 16'h0, 4'h2);
    rd(EXP_OFF, 16'h001F);
    rd(EXP_OFF, 16'h000D);
    rd(LPN_OFF, ~r[15:0]);
    for (k = 0; k < 2; k++) begin
      cyc(1'b0, 1'b0, 5'h0, k[15:0], 4'h1);
      rd(NPT_OFF, npt | (k == 0 ? 16'h0800 : 16'h0));
    end
    rd(IST_OFF, 16'h0007);
    wr(IST_OFF, 16'h0006);
    rd(IST_OFF, 16'h0001);
    irq_is(1'b1);
    cyc(1'b0, 1'b0, 5'h0, 16'h0, 4'h0);
    end_sim();
  end
endmodule
